// File: hdl/ucr_fifo.sv
// Purpose: receive byte fifo between usb side and cpu data port
// Assumes: one clock, push and pop in the same cycle allowed
// Notes:   depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module ucr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("ucr_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign count_o     = cnt_r;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt  = wp_r + AW'(push);
    rp_nxt  = rp_r + AW'(pop);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; content is only read behind a valid count
  always_ff @(posedge clk_i) begin
    if (push && !flush_i) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule // ucr_fifo
`default_nettype wire

// File: hdl/ucr_pkg.sv
// Purpose: shared constants and carriers for the usb client local register block
// Assumes: 16-bit register locations, byte offsets as printed
// Notes:   upper byte of every location reads zero
package ucr_pkg;

  localparam logic [15:0] UCR_BASE          = 16'h4000;
  localparam int          UCR_SPAN_BYTES    = 48;
  localparam logic [15:0] OFS_CONTROL       = 16'h4000;
  localparam logic [15:0] OFS_IRQ_EN_MAIN   = 16'h4002;
  localparam logic [15:0] OFS_IRQ_ST_MAIN   = 16'h4004;
  localparam logic [15:0] OFS_IRQ_EN_FIFO   = 16'h4006;
  localparam logic [15:0] OFS_IRQ_ST_FIFO   = 16'h4008;
  localparam logic [15:0] OFS_RX_MB_INDEX   = 16'h4010;
  localparam logic [15:0] OFS_RX_MB_DATA    = 16'h4012;
  localparam logic [15:0] OFS_TX_MB_INDEX   = 16'h4018;
  localparam logic [15:0] OFS_TX_MB_DATA    = 16'h401a;
  localparam logic [15:0] OFS_RX_FIFO_DATA  = 16'h4020;
  localparam logic [15:0] OFS_RX_FIFO_COUNT = 16'h4022;
  localparam logic [15:0] OFS_RX_ALMOST_THR = 16'h4024;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_THR  = 8'h06;

  // control bit positions
  localparam int CTL_CLK_GATE   = 7;
  localparam int CTL_SW_EOT     = 6;
  localparam int CTL_USB_EN     = 5;
  localparam int CTL_EP4_STALL  = 4;
  localparam int CTL_EP3_STALL  = 3;
  localparam int CTL_PIN_SEL    = 2;
  // main and fifo status bit positions
  localparam int IRQ_SUSPEND    = 7;
  localparam int IRQ_SOF        = 6;
  localparam int IRQ_EP4_SENT   = 4;
  localparam int IRQ_EP3_RCVD   = 3;
  localparam int IRQ_EP2_READ   = 2;
  localparam int IRQ_EP1_WRITE  = 1;
  localparam int IRQ_UPPER      = 0;
  localparam int IRQ_RX_AFULL   = 0;
  localparam int IRQ_TX_AEMPTY  = 1;
  // writable masks; reserved bits held at zero
  localparam logic [7:0] MASK_CONTROL = 8'hfc;
  localparam logic [7:0] MASK_EN_MAIN = 8'hde;
  localparam logic [7:0] MASK_EN_FIFO = 8'h03;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ucr_cpu_req_t;

  typedef struct packed {
    logic suspend;
    logic sof;
    logic ep4_sent;
    logic ep3_rcvd;
    logic ep2_read;
    logic ep1_write;
    logic tx_aempty;
  } ucr_usb_evt_t;

  typedef enum logic [1:0] {
    DESC_NONE  = 2'b00,
    DESC_ACK   = 2'b01,
    DESC_NAK   = 2'b10,
    DESC_STALL = 2'b11
  } ucr_hs_t;

endpackage : ucr_pkg

// File: hdl/ucr_regs.sv
// Purpose: local cpu register block of an embedded usb 1.1 client
// Assumes: cpu strobes are one-cycle, synchronous; usb events arrive as pulses
// Notes:   usb protocol engine sits outside and takes the answers below
//
// Notes on behaviour
// - The registers form a 48-byte region at the usb base reached by the cpu bus.
// - The usb clock gate depends only on its own bit, never on chip power save.
// - Descriptor reads get NAK until the usb enable bit is set.
// - With endpoint 4 stall set, bulk reads of the transmit fifo get STALL and no data.
// - With endpoint 3 stall set, bulk writes to the receive fifo get STALL and are dropped.
// - The pin select bit routes the four shared pins to usb when 1, to gpio when 0.
// - The main enable register gates suspend, sof, ep4 sent, ep3 received, ep2 and ep1 events.
// - Each event sets its main status bit; writing 1 clears it.
// - The 3-bit receive index selects the mailbox read and steps after each read, wrapping.
// - Eight receive mailboxes are filled by the host and read byte by byte by the cpu.
// - The 3-bit transmit index selects the mailbox accessed and steps after each access.
`timescale 1ns/10ps
`default_nettype none
module ucr_regs #(
  parameter int FIFO_DEPTH = 8,
  parameter int MB_COUNT   = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire ucr_pkg::ucr_cpu_req_t cpu_req_i,
  output logic               [15:0] cpu_rdata_o,
  output logic                      cpu_hit_o,
  input  wire ucr_pkg::ucr_usb_evt_t usb_evt_i,
  input  wire logic                 ep1_wr_i,
  input  wire logic           [2:0] ep1_wr_idx_i,
  input  wire logic           [7:0] ep1_wr_data_i,
  input  wire logic           [2:0] ep2_rd_idx_i,
  output logic                [7:0] ep2_rd_data_o,
  input  wire logic                 desc_req_i,
  output ucr_pkg::ucr_hs_t          desc_hs_o,
  input  wire logic                 ep4_in_req_i,
  output ucr_pkg::ucr_hs_t          ep4_hs_o,
  input  wire logic                 ep3_out_valid_i,
  input  wire logic           [7:0] ep3_out_data_i,
  output ucr_pkg::ucr_hs_t          ep3_hs_o,
  output logic                      usb_clk_en_o,
  output logic                      sw_eot_o,
  output logic                      pin_usb_sel_o,
  input  wire logic           [3:0] usb_pin_out_i,
  input  wire logic           [3:0] gpio_out_i,
  output logic                [3:0] pin_o
);
  import ucr_pkg::*;

  // index fields are 3 bits wide and the count register holds one byte
  generate
    if (MB_COUNT != 8) begin : g_bad_mb
      $error("ucr_regs: mailbox count must be 8");
    end
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_bad_depth
      $error("ucr_regs: fifo depth must lie between 2 and 128");
    end
  endgenerate

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic in_region, wr, rd;
  assign in_region = (cpu_req_i.addr >= UCR_BASE)
                   && (cpu_req_i.addr < UCR_BASE + 16'(UCR_SPAN_BYTES));
  assign wr = cpu_req_i.wr & in_region;
  assign rd = cpu_req_i.rd & in_region;
  assign cpu_hit_o = in_region & (cpu_req_i.wr | cpu_req_i.rd);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] en_main_r, en_main_nxt;
  logic [7:0] st_main_r, st_main_nxt;
  logic [7:0] en_fifo_r, en_fifo_nxt;
  logic [7:0] st_fifo_r, st_fifo_nxt;
  logic [7:0] thr_r, thr_nxt;
  logic [2:0] rx_idx_r, rx_idx_nxt;
  logic [2:0] tx_idx_r, tx_idx_nxt;
  logic [7:0] rx_mb_r [MB_COUNT];
  logic [7:0] tx_mb_r [MB_COUNT];
  logic [15:0] rdata_r, rdata_nxt;

  logic [7:0] ev_main;
  logic       rx_afull_ev, rx_push, rx_ready;
  logic       rx_pop, rx_valid;
  logic [7:0] rx_dout;
  logic [$clog2(FIFO_DEPTH):0] rx_cnt;

  // event sets are gated by the matching enable
  always_comb begin
    ev_main = '0;
    ev_main[IRQ_SUSPEND]   = usb_evt_i.suspend;
    ev_main[IRQ_SOF]       = usb_evt_i.sof;
    ev_main[IRQ_EP4_SENT]  = usb_evt_i.ep4_sent;
    ev_main[IRQ_EP3_RCVD]  = usb_evt_i.ep3_rcvd;
    ev_main[IRQ_EP2_READ]  = usb_evt_i.ep2_read;
    ev_main[IRQ_EP1_WRITE] = usb_evt_i.ep1_write | ep1_wr_i;
    ev_main = ev_main & en_main_r;
  end

  // almost-full: count at threshold and another byte taken in
  assign rx_afull_ev = rx_push && (8'(rx_cnt) == thr_r);

  always_comb begin
    ctl_nxt     = ctl_r;
    en_main_nxt = en_main_r;
    en_fifo_nxt = en_fifo_r;
    thr_nxt     = thr_r;
    rx_idx_nxt  = rx_idx_r;
    tx_idx_nxt  = tx_idx_r;
    st_main_nxt = st_main_r;
    st_fifo_nxt = st_fifo_r;
    if (wr) begin
      if (hit(cpu_req_i.addr, OFS_CONTROL))
        ctl_nxt = cpu_req_i.wdata & MASK_CONTROL;
      if (hit(cpu_req_i.addr, OFS_IRQ_EN_MAIN))
        en_main_nxt = cpu_req_i.wdata & MASK_EN_MAIN;
      if (hit(cpu_req_i.addr, OFS_IRQ_EN_FIFO))
        en_fifo_nxt = cpu_req_i.wdata & MASK_EN_FIFO;
      if (hit(cpu_req_i.addr, OFS_RX_ALMOST_THR))
        thr_nxt = cpu_req_i.wdata;
      if (hit(cpu_req_i.addr, OFS_RX_MB_INDEX))
        rx_idx_nxt = cpu_req_i.wdata[2:0];
      if (hit(cpu_req_i.addr, OFS_TX_MB_INDEX))
        tx_idx_nxt = cpu_req_i.wdata[2:0];
      if (hit(cpu_req_i.addr, OFS_IRQ_ST_MAIN))
        st_main_nxt = st_main_r & ~(cpu_req_i.wdata & MASK_EN_MAIN);
      if (hit(cpu_req_i.addr, OFS_IRQ_ST_FIFO))
        st_fifo_nxt = st_fifo_r & ~(cpu_req_i.wdata & MASK_EN_FIFO);
    end
    // set wins over a same-cycle clear
    st_main_nxt = st_main_nxt | ev_main;
    st_fifo_nxt[IRQ_RX_AFULL]  = st_fifo_nxt[IRQ_RX_AFULL]
                               | (rx_afull_ev & en_fifo_r[IRQ_RX_AFULL]);
    st_fifo_nxt[IRQ_TX_AEMPTY] = st_fifo_nxt[IRQ_TX_AEMPTY]
                               | (usb_evt_i.tx_aempty & en_fifo_r[IRQ_TX_AEMPTY]);
    st_main_nxt[IRQ_UPPER] = |st_fifo_nxt;
    // index step after data access, 3-bit wrap
    if (rd && hit(cpu_req_i.addr, OFS_RX_MB_DATA))
      rx_idx_nxt = rx_idx_r + 3'h1;
    if ((rd || wr) && hit(cpu_req_i.addr, OFS_TX_MB_DATA))
      tx_idx_nxt = tx_idx_r + 3'h1;
    if (!ctl_nxt[CTL_SW_EOT] || !usb_evt_i.ep4_sent) begin
    end else begin
      ctl_nxt[CTL_SW_EOT] = 1'b0;
    end
  end

  // read mux; upper byte always zero
  always_comb begin
    rdata_nxt = '0;
    if (rd) begin
      unique case (cpu_req_i.addr)
        OFS_CONTROL:       rdata_nxt[7:0] = ctl_r;
        OFS_IRQ_EN_MAIN:   rdata_nxt[7:0] = en_main_r;
        OFS_IRQ_ST_MAIN:   rdata_nxt[7:0] = st_main_r;
        OFS_IRQ_EN_FIFO:   rdata_nxt[7:0] = en_fifo_r;
        OFS_IRQ_ST_FIFO:   rdata_nxt[7:0] = st_fifo_r;
        OFS_RX_MB_INDEX:   rdata_nxt[7:0] = {5'h00, rx_idx_r};
        OFS_RX_MB_DATA:    rdata_nxt[7:0] = rx_mb_r[rx_idx_r];
        OFS_TX_MB_INDEX:   rdata_nxt[7:0] = {5'h00, tx_idx_r};
        OFS_TX_MB_DATA:    rdata_nxt[7:0] = tx_mb_r[tx_idx_r];
        OFS_RX_FIFO_DATA:  rdata_nxt[7:0] = rx_valid ? rx_dout : 8'h00;
        OFS_RX_FIFO_COUNT: rdata_nxt[7:0] = 8'(rx_cnt);
        OFS_RX_ALMOST_THR: rdata_nxt[7:0] = thr_r;
        default:           rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r     <= RST_BYTE;
      en_main_r <= RST_BYTE;
      st_main_r <= RST_BYTE;
      en_fifo_r <= RST_BYTE;
      st_fifo_r <= RST_BYTE;
      thr_r     <= RST_THR;
      rx_idx_r  <= 3'h0;
      tx_idx_r  <= 3'h0;
      rdata_r   <= 16'h0000;
    end else begin
      ctl_r     <= ctl_nxt;
      en_main_r <= en_main_nxt;
      st_main_r <= st_main_nxt;
      en_fifo_r <= en_fifo_nxt;
      st_fifo_r <= st_fifo_nxt;
      thr_r     <= thr_nxt;
      rx_idx_r  <= rx_idx_nxt;
      tx_idx_r  <= tx_idx_nxt;
      rdata_r   <= rdata_nxt;
    end
  end
  assign cpu_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // mailboxes
  logic [7:0]          rx_mb_nxt [MB_COUNT];
  logic [7:0]          tx_mb_nxt [MB_COUNT];
  logic [7:0]          ep2_rd_nxt;
  logic [MB_COUNT-1:0] rx_mb_we, tx_mb_we;
  logic                tx_mb_wr;

  assign tx_mb_wr = wr && hit(cpu_req_i.addr, OFS_TX_MB_DATA);

  // one strobe per byte; host and cpu sides never write the same bank
  genvar g;
  generate
    for (g = 0; g < MB_COUNT; g++) begin : g_mb
      assign rx_mb_we[g] = ep1_wr_i && (ep1_wr_idx_i == 3'(g));
      assign tx_mb_we[g] = tx_mb_wr && (tx_idx_r == 3'(g));
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < MB_COUNT; i++) begin
      rx_mb_nxt[i] = rx_mb_we[i] ? ep1_wr_data_i : rx_mb_r[i];
      tx_mb_nxt[i] = tx_mb_we[i] ? cpu_req_i.wdata : tx_mb_r[i];
    end
    // engine read is registered: one cycle from index to data
    ep2_rd_nxt = tx_mb_r[ep2_rd_idx_i];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < MB_COUNT; i++) begin
        rx_mb_r[i] <= RST_BYTE;
        tx_mb_r[i] <= RST_BYTE;
      end
      ep2_rd_data_o <= RST_BYTE;
    end else begin
      for (int i = 0; i < MB_COUNT; i++) begin
        rx_mb_r[i] <= rx_mb_nxt[i];
        tx_mb_r[i] <= tx_mb_nxt[i];
      end
      ep2_rd_data_o <= ep2_rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo; stall or full drops the byte
  assign rx_push = ep3_out_valid_i && !ctl_r[CTL_EP3_STALL] && rx_ready;
  assign rx_pop  = rd && hit(cpu_req_i.addr, OFS_RX_FIFO_DATA);

  ucr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (1'b0),
    .in_valid_i  (ep3_out_valid_i & ~ctl_r[CTL_EP3_STALL]),
    .in_ready_o  (rx_ready),
    .in_data_i   (ep3_out_data_i),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_dout),
    .count_o     (rx_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // handshake answers to the usb engine; combinational so the engine
  // can answer within the same token slot
  always_comb begin
    desc_hs_o = DESC_NONE;
    if (desc_req_i) begin
      desc_hs_o = ctl_r[CTL_USB_EN] ? DESC_ACK : DESC_NAK;
    end
  end

  always_comb begin
    ep4_hs_o = DESC_NONE;
    if (ep4_in_req_i) begin
      ep4_hs_o = ctl_r[CTL_EP4_STALL] ? DESC_STALL : DESC_ACK;
    end
  end

  // a full fifo refuses with nak so the host retries later
  always_comb begin
    ep3_hs_o = DESC_NONE;
    if (ep3_out_valid_i) begin
      ep3_hs_o = ctl_r[CTL_EP3_STALL] ? DESC_STALL
               : (rx_ready ? DESC_ACK : DESC_NAK);
    end
  end

  // gate follows only its own bit; no power-save input exists
  assign usb_clk_en_o  = ctl_r[CTL_CLK_GATE];
  assign sw_eot_o      = ctl_r[CTL_SW_EOT];
  assign pin_usb_sel_o = ctl_r[CTL_PIN_SEL];
  always_comb begin
    pin_o = ctl_r[CTL_PIN_SEL] ? usb_pin_out_i : gpio_out_i;
  end
endmodule // ucr_regs
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench for the usb client register block
// Assumes: cpu sets clock gate and pin select before other accesses
// Notes:   gpio and usb pin sources held constant
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ucr_pkg::*;
  logic clk_i, rst_i, ep1_wr, desc_req, ep4_req, ep3_v, gate, eot, sel, hit;
  ucr_cpu_req_t req;
  ucr_usb_evt_t evt;
  ucr_hs_t dhs, e4hs, e3hs, hs;
  logic [15:0] cpu_rdata_o;
  logic [7:0] ep1_d, ep2_d, ep3_d, b;
  logic [2:0] ep1_i, ep2_i;
  logic [3:0] upin, pin;
  int failures = 0, cmp_count = 0;
  ucr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(req), .cpu_rdata_o(cpu_rdata_o),
    .cpu_hit_o(hit), .usb_evt_i(evt), .ep1_wr_i(ep1_wr), .ep1_wr_idx_i(ep1_i),
    .ep1_wr_data_i(ep1_d), .ep2_rd_idx_i(ep2_i), .ep2_rd_data_o(ep2_d), .desc_req_i(desc_req),
    .desc_hs_o(dhs), .ep4_in_req_i(ep4_req), .ep4_hs_o(e4hs), .ep3_out_valid_i(ep3_v),
    .ep3_out_data_i(ep3_d), .ep3_hs_o(e3hs), .usb_clk_en_o(gate), .sw_eot_o(eot),
    .pin_usb_sel_o(sel), .usb_pin_out_i(upin), .gpio_out_i(4'h5), .pin_o(pin));
  ucr_host_model u_host (.clk_i(clk_i), .ep2_rd_data_i(ep2_d), .usb_evt_o(evt),
    .ep1_wr_o(ep1_wr), .ep1_wr_idx_o(ep1_i), .ep1_wr_data_o(ep1_d), .ep2_rd_idx_o(ep2_i),
    .desc_req_o(desc_req), .ep4_in_req_o(ep4_req), .ep3_out_valid_o(ep3_v),
    .ep3_out_data_o(ep3_d), .usb_pin_out_o(upin), .ep3_hs_i(e3hs));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i);
    #1 req.wr = 1'b0;
  endtask
  task automatic rchk(string n, input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    #1 req.rd = 1'b0;
    chk(n, cpu_rdata_o, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_setup;
    logic [15:0] ofs[6] = '{OFS_IRQ_EN_MAIN, OFS_IRQ_ST_MAIN, OFS_IRQ_EN_FIFO,
                            OFS_IRQ_ST_FIFO, OFS_RX_MB_INDEX, OFS_TX_MB_INDEX};
    wr(OFS_CONTROL, 8'h84);
    rchk("control", OFS_CONTROL, 16'h0084);
    chk("gate and pin select", {14'h0, gate, sel}, 16'h0003);
    foreach (ofs[i]) rchk("reset value", ofs[i], 16'h0000);
    rchk("unmapped", 16'h4030, 16'h0000);
  endtask
  task automatic t_ctrl;
    wr(OFS_CONTROL, 8'hbc);
    rchk("control", OFS_CONTROL, 16'h00bc);
    chk("pins usb", {12'h000, pin}, 16'h000a);
    u_host.req(1'b1, 1'b1);
    #5 chk("ep4 stall", {14'h0, e4hs}, {14'h0, DESC_STALL});
    chk("desc ack", {14'h0, dhs}, {14'h0, DESC_ACK});
    u_host.push(8'h77, hs);
    chk("ep3 stall", {14'h0, hs}, {14'h0, DESC_STALL});
    rchk("dropped", OFS_RX_FIFO_COUNT, 16'h0000);
    wr(OFS_CONTROL, 8'h84);
    #5 chk("desc nak", {14'h0, dhs}, {14'h0, DESC_NAK});
    wr(OFS_CONTROL, 8'h80);
    chk("pins gpio", {12'h000, pin}, 16'h0005);
    wr(OFS_CONTROL, 8'h84);
    wr(OFS_CONTROL, 8'hc4);
    chk("eot set", {15'h0, eot}, 16'h0001);
    u_host.evt(7'h10);
    chk("eot auto clear", {15'h0, eot}, 16'h0000);
    u_host.req(1'b0, 1'b0);
  endtask
  task automatic t_irq;
    logic [6:0] ev[6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02};
    logic [7:0] sb[6] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02};
    u_host.evt(7'h40);
    rchk("masked", OFS_IRQ_ST_MAIN, 16'h0000);
    wr(OFS_IRQ_EN_MAIN, 8'hde);
    foreach (ev[i]) begin
      u_host.evt(ev[i]);
      rchk("status set", OFS_IRQ_ST_MAIN, {8'h00, sb[i]});
      wr(OFS_IRQ_ST_MAIN, sb[i]);
      rchk("status clear", OFS_IRQ_ST_MAIN, 16'h0000);
    end
    wr(OFS_IRQ_EN_MAIN, 8'h00);
  endtask
  task automatic t_mb;
    for (int i = 0; i < 8; i++) u_host.ep1(3'(i), 8'ha0 + 8'(i));
    wr(OFS_RX_MB_INDEX, 8'h06);
    for (int i = 6; i < 9; i++) rchk("rx mailbox", OFS_RX_MB_DATA, {8'h00, 8'ha0 + 8'(i % 8)});
    rchk("rx index", OFS_RX_MB_INDEX, 16'h0001);
    wr(OFS_TX_MB_INDEX, 8'h07);
    wr(OFS_TX_MB_DATA, 8'h5a);
    wr(OFS_TX_MB_DATA, 8'h3c);
    rchk("tx index", OFS_TX_MB_INDEX, 16'h0001);
    u_host.tx_rd(3'h7, b);
    chk("tx mailbox 7", {8'h00, b}, 16'h005a);
    u_host.tx_rd(3'h0, b);
    chk("tx mailbox 0", {8'h00, b}, 16'h003c);
  endtask
  task automatic t_fifo;
    wr(OFS_IRQ_EN_FIFO, 8'h01);
    for (int i = 0; i < 9; i++) begin
      u_host.push(8'h10 + 8'(i), hs);
      chk("push answer", {14'h0, hs}, {14'h0, (i < 8) ? DESC_ACK : DESC_NAK});
      if (i == int'(RST_THR) - 1) rchk("afull early", OFS_IRQ_ST_FIFO, 16'h0000);
      if (i == int'(RST_THR)) rchk("afull", OFS_IRQ_ST_FIFO, 16'h0001);
    end
    rchk("fifo count", OFS_RX_FIFO_COUNT, 16'h0008);
    rchk("upper active", OFS_IRQ_ST_MAIN, 16'h0001);
    for (int i = 0; i < 8; i++) rchk("fifo data", OFS_RX_FIFO_DATA, {8'h00, 8'h10 + 8'(i)});
    rchk("fifo empty", OFS_RX_FIFO_COUNT, 16'h0000);
    wr(OFS_IRQ_ST_FIFO, 8'h01);
    rchk("afull clear", OFS_IRQ_ST_FIFO, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  initial begin
    req = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_setup();
    t_ctrl();
    t_irq();
    t_mb();
    t_fifo();
    end_sim();
  end
endmodule // tb
`default_nettype wire

// File: sim/ucr_host_model.sv
// Purpose: behavioural usb engine side driving the block's far ports
// Assumes: one-cycle pulses, changes just after the rising edge
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module ucr_host_model (
  input wire logic                  clk_i,
  input wire logic            [7:0] ep2_rd_data_i,
  input wire ucr_pkg::ucr_hs_t      ep3_hs_i,
  output ucr_pkg::ucr_usb_evt_t     usb_evt_o,
  output logic                      ep1_wr_o,
  output logic                [2:0] ep1_wr_idx_o,
  output logic                [7:0] ep1_wr_data_o,
  output logic                [2:0] ep2_rd_idx_o,
  output logic                      desc_req_o,
  output logic                      ep4_in_req_o,
  output logic                      ep3_out_valid_o,
  output logic                [7:0] ep3_out_data_o,
  output logic                [3:0] usb_pin_out_o
);
  import ucr_pkg::*;
  initial begin
    usb_evt_o = '0;
    {ep1_wr_o, ep1_wr_idx_o, ep1_wr_data_o, ep2_rd_idx_o} = '0;
    {desc_req_o, ep4_in_req_o, ep3_out_valid_o, ep3_out_data_o} = '0;
    usb_pin_out_o = 4'ha;
  end
  task automatic evt(input logic [6:0] e);
    @(posedge clk_i);
    #1 usb_evt_o = ucr_usb_evt_t'(e);
    @(posedge clk_i);
    #1 usb_evt_o = '0;
  endtask
  task automatic ep1(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    #1 {ep1_wr_o, ep1_wr_idx_o, ep1_wr_data_o} = {1'b1, i, d};
    @(posedge clk_i);
    #1 {ep1_wr_o, ep1_wr_data_o} = {1'b0, ~d};
  endtask
  // handshake is combinational, so sample it 6 ns after the rising edge
  task automatic push(input logic [7:0] d, output ucr_hs_t hs);
    @(posedge clk_i);
    #1 {ep3_out_valid_o, ep3_out_data_o} = {1'b1, d};
    #5 hs = ep3_hs_i;
    @(posedge clk_i);
    #1 {ep3_out_valid_o, ep3_out_data_o} = {1'b0, ~d};
  endtask
  task automatic tx_rd(input logic [2:0] i, output logic [7:0] d);
    @(posedge clk_i);
    #1 ep2_rd_idx_o = i;
    @(posedge clk_i);
    #1 d = ep2_rd_data_i;
  endtask
  task automatic req(input logic dr, input logic ir);
    @(posedge clk_i);
    #1 {desc_req_o, ep4_in_req_o} = {dr, ir};
  endtask
endmodule // ucr_host_model
`default_nettype wire

// File: sim/ucr_regs_checker.sv
// Purpose: port-level checks on the usb client register block
// Assumes: control bits mirrored from cpu writes; sw eot bit not tracked
// Notes:   attached by bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module ucr_regs_checker (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire ucr_pkg::ucr_cpu_req_t cpu_req_i,
  input wire logic           [15:0] cpu_rdata_o,
  input wire logic                  cpu_hit_o,
  input wire logic                  desc_req_i,
  input wire ucr_pkg::ucr_hs_t      desc_hs_o,
  input wire logic                  ep4_in_req_i,
  input wire ucr_pkg::ucr_hs_t      ep4_hs_o,
  input wire logic                  ep3_out_valid_i,
  input wire ucr_pkg::ucr_hs_t      ep3_hs_o,
  input wire logic                  usb_clk_en_o,
  input wire logic                  pin_usb_sel_o,
  input wire logic            [3:0] usb_pin_out_i,
  input wire logic            [3:0] gpio_out_i,
  input wire logic            [3:0] pin_o
);
  import ucr_pkg::*;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    if (cpu_req_i.wr && cpu_req_i.addr == OFS_CONTROL) ctl_nxt = cpu_req_i.wdata & MASK_CONTROL;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ctl_r <= 8'h00;
    else ctl_r <= ctl_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  a_hit_range: assert property ((cpu_req_i.rd || cpu_req_i.wr) |-> cpu_hit_o ==
    (cpu_req_i.addr >= 16'h4000 && cpu_req_i.addr < 16'h4030)) else $error("hit flag wrong");
  a_miss_zero: assert property (cpu_req_i.rd && !cpu_hit_o |=> cpu_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (cpu_rdata_o[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_clk_gate: assert property (usb_clk_en_o == ctl_r[CTL_CLK_GATE])
    else $error("clock gate not following bit");
  a_pin_sel: assert property (pin_usb_sel_o == ctl_r[CTL_PIN_SEL])
    else $error("pin select not following bit");
  a_pin_mux: assert property (pin_o == (ctl_r[CTL_PIN_SEL] ? usb_pin_out_i : gpio_out_i))
    else $error("shared pins wrongly routed");
  a_desc_nak: assert property (desc_req_i && !ctl_r[CTL_USB_EN] |-> desc_hs_o == DESC_NAK)
    else $error("descriptor not refused");
  a_ep4_stall: assert property (ep4_in_req_i && ctl_r[CTL_EP4_STALL] |-> ep4_hs_o == DESC_STALL)
    else $error("bulk read not stalled");
  a_ep3_stall: assert property (ep3_out_valid_i && ctl_r[CTL_EP3_STALL] |-> ep3_hs_o == DESC_STALL)
    else $error("bulk write not stalled");
endmodule // ucr_regs_checker

bind ucr_regs ucr_regs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_i),
  .cpu_rdata_o(cpu_rdata_o), .cpu_hit_o(cpu_hit_o), .desc_req_i(desc_req_i),
  .desc_hs_o(desc_hs_o), .ep4_in_req_i(ep4_in_req_i), .ep4_hs_o(ep4_hs_o),
  .ep3_out_valid_i(ep3_out_valid_i), .ep3_hs_o(ep3_hs_o), .usb_clk_en_o(usb_clk_en_o),
  .pin_usb_sel_o(pin_usb_sel_o), .usb_pin_out_i(usb_pin_out_i), .gpio_out_i(gpio_out_i),
  .pin_o(pin_o));
`default_nettype wire
